/* File: adc_frame_pkg.sv */
// constants for the converter frame readout path
// assumes one 200 MHz system clock; serial pins are sampled, not used as clocks
package adc_frame_pkg;

    // frame layout
    localparam int unsigned CH_COUNT    = 8;
    localparam int unsigned WORD_BITS   = 24;
    localparam int unsigned RAW_BITS    = 26;
    localparam int unsigned BANK_COUNT  = 2;
    localparam int unsigned MEM_DEPTH   = CH_COUNT * BANK_COUNT;
    localparam int unsigned ADDR_BITS   = 4;
    localparam int unsigned GPIO_BITS   = 4;
    localparam int unsigned FAULT_BITS  = 8;

    // status word field positions
    localparam int unsigned STAT_POS_LSB  = 16;
    localparam int unsigned STAT_NEG_LSB  = 8;
    localparam int unsigned STAT_GPIO_LSB = 4;
    localparam logic [3:0]  STAT_PAD      = 4'h0;

    // word lengths and frame counts, as index of the last bit, word or channel
    localparam logic [4:0] WIDE_LAST   = 5'h17;
    localparam logic [4:0] NARROW_LAST = 5'h0F;
    localparam logic [3:0] LAST_WORD   = 4'h8;
    localparam logic [2:0] LOAD_LAST   = 3'h7;

    // rate select codes that give 16-bit results
    localparam logic [2:0] RATE_NARROW_A = 3'h0;
    localparam logic [2:0] RATE_NARROW_B = 3'h1;

    // clipping limits: 24-bit ones on the raw result scale, 16-bit ones after the NARROW_SHIFT right shift
    localparam int unsigned NARROW_SHIFT = 8;
    localparam logic signed [RAW_BITS-1:0] LIM16_HI = 26'sh0007FFF;
    localparam logic signed [RAW_BITS-1:0] LIM16_LO = 26'sh3FF8000;
    localparam logic signed [RAW_BITS-1:0] LIM24_HI = 26'sh07FFFFF;
    localparam logic signed [RAW_BITS-1:0] LIM24_LO = 26'sh3800000;
    localparam logic [15:0] SAT16_POS = 16'h7FFF;
    localparam logic [15:0] SAT16_NEG = 16'h8000;
    localparam logic [23:0] SAT24_POS = 24'h7FFFFF;
    localparam logic [23:0] SAT24_NEG = 24'h800000;

    // reset values
    localparam logic FLAG_IDLE = 1'b1;

endpackage

/* File: frame_snapshot_mem.sv */
// two banks of eight channel words, registered read data
// assumes writer and reader never use the same bank at the same time
`timescale 1ns/10ps
module frame_snapshot_mem
    import adc_frame_pkg::*;
(
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    // write port
    input  wire logic                 wr_en,
    input  wire logic [ADDR_BITS-1:0] wr_addr,
    input  wire logic [WORD_BITS-1:0] wr_data,
    // read port
    input  wire logic [ADDR_BITS-1:0] rd_addr,
    output logic      [WORD_BITS-1:0] rd_data
);

    logic [WORD_BITS-1:0] mem_q [MEM_DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem_q[rd_addr];
        end
    end

endmodule

/* File: adc_frame_readout.sv */
// serial frame readout: data-ready flag, snapshot banks and output shifter
// assumes serial clock, chip select and data in come from pins of a host master
`timescale 1ns/10ps
module adc_frame_readout
    import adc_frame_pkg::*;
(
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          arst_n,
    // serial pins
    input  wire logic                          sclk,
    input  wire logic                          cs_n,
    input  wire logic                          din,
    output logic                               serial_out,
    output logic                               serial_out_oe,
    output logic                               conversion_done_flag_n,
    // command decoder side
    output logic                               serial_in_bit,
    output logic                               serial_in_valid,
    input  wire logic                          single_read_req,
    input  wire logic                          continuous_read_mode,
    input  wire logic                          chain_input_enable,
    input  wire logic [2:0]                    rate_select_field,
    // converter side
    input  wire logic                          conv_valid,
    output logic                               conv_busy,
    input  wire logic [CH_COUNT*RAW_BITS-1:0]  channel_results,
    input  wire logic [CH_COUNT-1:0]           channel_powered_down,
    input  wire logic [FAULT_BITS-1:0]         positive_fault_flags,
    input  wire logic [FAULT_BITS-1:0]         negative_fault_flags,
    input  wire logic [GPIO_BITS-1:0]          gpio_data
);

    typedef struct packed {
        logic                             sclk_m;
        logic                             sclk_s;
        logic                             sclk_p;
        logic                             cs_m;
        logic                             cs_s;
        logic                             cs_p;
        logic                             din_m;
        logic                             din_s;
        logic                             flag_n;
        logic                             load_busy;
        logic [2:0]                       load_idx;
        logic                             wr_bank;
        logic                             rd_bank;
        logic                             latest;
        logic                             rd_pend;
        logic [BANK_COUNT-1:0][WORD_BITS-1:0] stat;
        logic [BANK_COUNT-1:0]            narrow_b;
        logic [WORD_BITS-1:0]             sh;
        logic [4:0]                       bit_cnt;
        logic [3:0]                       word_idx;
        logic                             done;
        logic                             dout;
        logic                             din_bit;
        logic                             din_valid;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic                 sclk_rise;
    logic                 sclk_fall;
    logic                 cs_rise;
    logic                 load_last;
    logic                 start;
    logic                 src;
    logic [4:0]           last_bit;
    logic                 mem_we;
    logic [ADDR_BITS-1:0] mem_waddr;
    logic [WORD_BITS-1:0] mem_wdata;
    logic [ADDR_BITS-1:0] mem_raddr;
    logic [WORD_BITS-1:0] mem_rdata;
    logic signed [RAW_BITS-1:0] raw_sel;

    function automatic logic is_narrow(input logic [2:0] rate);
        is_narrow = (rate == RATE_NARROW_A) || (rate == RATE_NARROW_B);
    endfunction

    // clip to the selected width; 16-bit words sit in the upper bits
    function automatic logic [WORD_BITS-1:0] sat_word(input logic signed [RAW_BITS-1:0] raw,
                                                      input logic                       narrow);
        logic signed [RAW_BITS-1:0] v;
        logic [WORD_BITS-1:0]       r;
        v = raw;
        r = '0;
        if (narrow) begin
            v = raw >>> NARROW_SHIFT;
            if (v > LIM16_HI) begin
                r = {SAT16_POS, 8'h00};
            end else if (v < LIM16_LO) begin
                r = {SAT16_NEG, 8'h00};
            end else begin
                r = {v[15:0], 8'h00};
            end
        end else begin
            if (v > LIM24_HI) begin
                r = SAT24_POS;
            end else if (v < LIM24_LO) begin
                r = SAT24_NEG;
            end else begin
                r = v[WORD_BITS-1:0];
            end
        end
        sat_word = r;
    endfunction

    assign sclk_rise = s_q.sclk_s & ~s_q.sclk_p;
    assign sclk_fall = ~s_q.sclk_s & s_q.sclk_p;
    assign cs_rise   = s_q.cs_s & ~s_q.cs_p;
    assign load_last = s_q.load_busy && (s_q.load_idx == LOAD_LAST);
    assign last_bit  = (s_q.word_idx == 4'h0 || !s_q.narrow_b[s_q.rd_bank]) ? WIDE_LAST : NARROW_LAST;

    // snapshot writes go to the bank that no readout uses
    assign raw_sel   = channel_results[s_q.load_idx*RAW_BITS +: RAW_BITS];
    assign mem_we    = s_q.load_busy;
    assign mem_waddr = {s_q.wr_bank, s_q.load_idx};
    assign mem_wdata = channel_powered_down[s_q.load_idx] ? '0 : sat_word(raw_sel, s_q.narrow_b[s_q.wr_bank]);
    assign mem_raddr = {s_q.rd_bank, s_q.word_idx[2:0]};

    always_comb begin
        s_d = s_q;
        start = 1'b0;
        src   = s_q.latest;
        // pin synchronisers
        s_d.sclk_m    = sclk;
        s_d.sclk_s    = s_q.sclk_m;
        s_d.sclk_p    = s_q.sclk_s;
        s_d.cs_m      = cs_n;
        s_d.cs_s      = s_q.cs_m;
        s_d.cs_p      = s_q.cs_s;
        s_d.din_m     = din;
        s_d.din_s     = s_q.din_m;
        s_d.din_valid = 1'b0;

        if (sclk_fall) begin
            s_d.flag_n = 1'b1;
            if (!s_q.cs_s) begin
                s_d.din_bit   = s_q.din_s;
                s_d.din_valid = 1'b1;
            end
        end

        // result loader, one channel word per cycle
        if (s_q.load_busy) begin
            s_d.load_idx = s_q.load_idx + 3'h1;
            if (load_last) begin
                s_d.load_busy = 1'b0;
                s_d.latest    = s_q.wr_bank;
                s_d.flag_n    = 1'b0;
                if (continuous_read_mode || s_q.rd_pend) begin
                    start       = 1'b1;
                    src         = s_q.wr_bank;
                    s_d.rd_pend = 1'b0;
                end
            end
        end else if (conv_valid) begin
            s_d.load_busy = 1'b1;
            s_d.load_idx  = 3'h0;
            s_d.wr_bank   = (s_q.latest != s_q.rd_bank) ? s_q.latest : ~s_q.rd_bank;
            s_d.stat[s_d.wr_bank] = {positive_fault_flags, negative_fault_flags, gpio_data, STAT_PAD};
            s_d.narrow_b[s_d.wr_bank] = is_narrow(rate_select_field);
        end

        // single read: wait for a load in flight rather than read half a set
        if (single_read_req) begin
            if ((s_q.load_busy && !load_last) || (!s_q.load_busy && conv_valid)) begin
                s_d.rd_pend = 1'b1;
            end else begin
                start = 1'b1;
                src   = load_last ? s_q.wr_bank : s_q.latest;
            end
        end

        // output shifter
        if (start) begin
            s_d.rd_bank  = src;
            s_d.sh       = s_q.stat[src];
            s_d.bit_cnt  = 5'h00;
            s_d.word_idx = 4'h0;
            s_d.done     = 1'b0;
        end else if (cs_rise) begin
            s_d.sh       = s_q.stat[s_q.rd_bank];
            s_d.bit_cnt  = 5'h00;
            s_d.word_idx = 4'h0;
            s_d.done     = 1'b0;
        end else if (sclk_rise && !s_q.cs_s) begin
            s_d.dout    = s_q.done ? 1'b0 : s_q.sh[WORD_BITS-1];
            s_d.sh      = {s_q.sh[WORD_BITS-2:0], 1'b0};
            s_d.bit_cnt = s_q.bit_cnt + 5'h01;
            if (s_q.bit_cnt == last_bit) begin
                s_d.bit_cnt = 5'h00;
                if (s_q.word_idx == LAST_WORD) begin
                    if (chain_input_enable) begin
                        s_d.word_idx = 4'h0;
                        s_d.sh       = s_q.stat[s_q.rd_bank];
                    end else begin
                        s_d.done = 1'b1;
                    end
                end else begin
                    s_d.word_idx = s_q.word_idx + 4'h1;
                    s_d.sh       = mem_rdata;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{flag_n: FLAG_IDLE, sclk_m: 1'b0, sclk_s: 1'b0, sclk_p: 1'b0,
                     cs_m: 1'b1, cs_s: 1'b1, cs_p: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    frame_snapshot_mem u_mem (
        .clock   (clock),
        .arst_n  (arst_n),
        .wr_en   (mem_we),
        .wr_addr (mem_waddr),
        .wr_data (mem_wdata),
        .rd_addr (mem_raddr),
        .rd_data (mem_rdata)
    );

    assign serial_out             = s_q.dout;
    assign serial_out_oe          = ~s_q.cs_s;
    assign conversion_done_flag_n = s_q.flag_n;
    assign serial_in_bit          = s_q.din_bit;
    assign serial_in_valid        = s_q.din_valid;
    assign conv_busy              = s_q.load_busy;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    a_flag_falls: assert property (load_last |=> !conversion_done_flag_n)
        else $error("flag did not fall after result load");
    a_flag_cs_free: assert property ((load_last && s_q.cs_s) |=> !conversion_done_flag_n)
        else $error("flag held off by chip select");
    a_flag_clear: assert property ((sclk_fall && !load_last) |=> conversion_done_flag_n)
        else $error("flag not cleared by falling serial clock");
    a_out_on_rise: assert property ($changed(serial_out) |-> $past(sclk_rise))
        else $error("serial output changed off a rising edge");
    a_status_msb: assert property ((sclk_rise && !s_q.cs_s && !s_q.done && s_q.word_idx == 4'h0
                                    && s_q.bit_cnt == 5'h00 && !start && !cs_rise)
                                   |=> serial_out == $past(s_q.stat[s_q.rd_bank][WORD_BITS-1]))
        else $error("first bit is not status msb");
    a_word_order: assert property ((sclk_rise && !s_q.cs_s && !start && !cs_rise && s_q.bit_cnt == last_bit
                                    && s_q.word_idx != LAST_WORD) |=> s_q.word_idx == $past(s_q.word_idx) + 4'h1)
        else $error("channel words out of order");
    a_narrow_len: assert property ((sclk_rise && !s_q.cs_s && !start && !cs_rise && s_q.word_idx != 4'h0
                                    && s_q.narrow_b[s_q.rd_bank] && s_q.bit_cnt == NARROW_LAST)
                                   |=> s_q.bit_cnt == 5'h00)
        else $error("16-bit word length wrong");
    a_narrow_pad: assert property ((mem_we && s_q.narrow_b[s_q.wr_bank]) |-> mem_wdata[7:0] == 8'h00)
        else $error("16-bit word not aligned");
    a_down_zero: assert property ((mem_we && channel_powered_down[s_q.load_idx]) |-> mem_wdata == '0)
        else $error("powered-down channel not zero");
    a_snap_apart: assert property (mem_we |-> mem_waddr[ADDR_BITS-1] != s_q.rd_bank)
        else $error("load overwrote bank being read");
    a_hiz_cs: assert property ($past(cs_n, 2) |-> !serial_out_oe)
        else $error("output driven while deselected");
    a_chain_wrap: assert property ((sclk_rise && !s_q.cs_s && !start && !cs_rise && chain_input_enable
                                    && s_q.word_idx == LAST_WORD && s_q.bit_cnt == last_bit)
                                   |=> s_q.word_idx == 4'h0 && !s_q.done)
        else $error("frame did not repeat");

    c_single_read: cover property (single_read_req && !s_q.load_busy && !conv_valid);
    c_continuous: cover property (load_last && continuous_read_mode);
    c_chain_wrap: cover property (sclk_rise && chain_input_enable && s_q.word_idx == LAST_WORD
                                  && s_q.bit_cnt == last_bit);
    c_pend_read: cover property (single_read_req && s_q.load_busy && !load_last);

endmodule

/* File: serial_host.sv */
// host-side serial master model: drives clock, select and data in
// assumes the bench calls its tasks one at a time; clock stands still between frames
`timescale 1ns/10ps
module serial_host (
    // serial pins
    output logic       sclk,
    output logic       cs_n,
    output logic       din,
    input  wire logic  dout_pin
);
    logic [215:0] rx_bits;

    initial begin
        sclk    = 1'b0;
        cs_n    = 1'b1;
        din     = 1'b0;
        rx_bits = '0;
    end

    // odd settle time keeps the link out of phase with the system clock
    task automatic select(input logic en);
        cs_n = ~en;
        #47.3;
    endtask

    // 80 ns per bit, data pin sampled just before the falling edge
    task automatic shift(input int n, input logic d);
        for (int i = 0; i < n; i++) begin
            din  = d;
            sclk = 1'b1;
            #40;
            rx_bits = {rx_bits[214:0], dout_pin};
            sclk = 1'b0;
            #40;
        end
        din = 1'b0;
    endtask
endmodule

/* File: tb.sv */
// self-checking bench for the frame readout block
// assumes the host model drives the serial pins; converter side driven here
`timescale 1ns/10ps
module tb
    import adc_frame_pkg::*;
;
    logic                         clock;
    logic                         arst_n;
    logic                         single_read_req;
    logic                         continuous_read_mode;
    logic                         chain_input_enable;
    logic [2:0]                   rate_select_field;
    logic                         conv_valid;
    logic [CH_COUNT*RAW_BITS-1:0] channel_results;
    logic [CH_COUNT-1:0]          channel_powered_down;
    logic [FAULT_BITS-1:0]        positive_fault_flags;
    logic [FAULT_BITS-1:0]        negative_fault_flags;
    logic [GPIO_BITS-1:0]         gpio_data;
    wire                          sclk;
    wire                          cs_n;
    wire                          din;
    wire                          dout_pin;
    logic                         serial_out;
    logic                         serial_out_oe;
    logic                         flag_n;
    logic                         serial_in_bit;
    logic                         serial_in_valid;
    logic                         conv_busy;
    logic                         last_in;
    int                           n_errors = 0;
    int                           cmp_count = 0;
    int                           n_in = 0;
    int                           cycles = 0;

    assign dout_pin = serial_out_oe ? serial_out : 1'bz;

    adc_frame_readout dut_u (
        .clock(clock), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe), .conversion_done_flag_n(flag_n),
        .serial_in_bit(serial_in_bit), .serial_in_valid(serial_in_valid),
        .single_read_req(single_read_req), .continuous_read_mode(continuous_read_mode),
        .chain_input_enable(chain_input_enable), .rate_select_field(rate_select_field),
        .conv_valid(conv_valid), .conv_busy(conv_busy), .channel_results(channel_results),
        .channel_powered_down(channel_powered_down), .positive_fault_flags(positive_fault_flags),
        .negative_fault_flags(negative_fault_flags), .gpio_data(gpio_data)
    );

    serial_host host_u (.sclk(sclk), .cs_n(cs_n), .din(din), .dout_pin(dout_pin));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock) begin
        if (serial_in_valid === 1'b1) begin
            n_in    <= n_in + 1;
            last_in <= serial_in_bit;
        end
    end

    // hang guard, well above the roughly 30k cycles the run needs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic [215:0] got, input logic [215:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wrap_up();
        $display("errors=%0d comparisons=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // expected frame, right-aligned: status then channels one to eight
    function automatic logic [215:0] frame(input logic narrow);
        logic signed [25:0] r;
        logic signed [25:0] v;
        logic [23:0]        w;
        logic [215:0]       f;
        f = 216'({positive_fault_flags, negative_fault_flags, gpio_data, 4'h0});
        for (int k = 0; k < CH_COUNT; k++) begin
            r = channel_powered_down[k] ? 26'h0 : channel_results[k*RAW_BITS +: RAW_BITS];
            v = narrow ? r >>> 8 : r;
            if (narrow)
                w = v > 32767 ? 24'h7FFF : (v < -32768 ? 24'h8000 : 24'(v[15:0]));
            else
                w = v > 8388607 ? 24'h7FFFFF : (v < -8388608 ? 24'h800000 : v[23:0]);
            f = narrow ? {f[199:0], w[15:0]} : {f[191:0], w};
        end
        return f;
    endfunction

    task automatic do_load();
        conv_valid = 1'b1;
        tick(1);
        conv_valid = 1'b0;
        tick(7);
        chk(216'({conv_busy, flag_n}), 216'h3);
        tick(1);
        chk(216'({conv_busy, flag_n}), 216'h0);
    endtask

    task automatic single_read();
        single_read_req = 1'b1;
        tick(1);
        single_read_req = 1'b0;
    endtask

    task automatic t_flag_cs();
        do_load();
        host_u.shift(1, 1'b0);
        tick(6);
        chk(216'(flag_n), 216'h1);
        chk(216'(dout_pin), 216'(1'bz));
    endtask

    task automatic t_din();
        int n0;
        host_u.select(1'b1);
        n0 = n_in;
        host_u.shift(1, 1'b1);
        tick(6);
        chk(216'({8'(n_in - n0), last_in}), 216'h3);
        host_u.select(1'b0);
    endtask

    task automatic t_wide();
        for (int r = 2; r <= 6; r++) begin
            rate_select_field  = 3'(r);
            chain_input_enable = (r == 6);
            positive_fault_flags = positive_fault_flags + 8'h11;
            negative_fault_flags = ~negative_fault_flags;
            gpio_data            = gpio_data ^ 4'(r);
            do_load();
            single_read();
            host_u.select(1'b1);
            host_u.shift(216, 1'b0);
            chk(host_u.rx_bits, frame(1'b0));
            if (r == 6) begin
                host_u.shift(24, 1'b0);
                chk(216'(host_u.rx_bits[23:0]), frame(1'b0) >> 192);
            end
            host_u.select(1'b0);
        end
        chain_input_enable = 1'b0;
    endtask

    task automatic t_narrow();
        continuous_read_mode = 1'b1;
        for (int r = 0; r <= 1; r++) begin
            rate_select_field    = 3'(r);
            channel_powered_down = 8'(r + 1);
            host_u.select(1'b1);
            do_load();
            host_u.shift(152, 1'b0);
            chk(216'(host_u.rx_bits[151:0]), frame(1'b1));
            host_u.select(1'b0);
        end
        continuous_read_mode = 1'b0;
    endtask

    task automatic t_overlap();
        logic [215:0] old_f;
        rate_select_field = 3'h2;
        do_load();
        old_f = frame(1'b0);
        single_read();
        host_u.select(1'b1);
        fork
            host_u.shift(216, 1'b0);
            begin
                tick(1000);
                channel_results = ~channel_results;
                do_load();
            end
        join
        chk(host_u.rx_bits, old_f);
        host_u.select(1'b0);
        gpio_data  = ~gpio_data;
        conv_valid = 1'b1;
        tick(1);
        conv_valid = 1'b0;
        tick(2);
        single_read(); // deferred until the load in flight ends
        tick(8);
        chk(216'(flag_n), 216'h0);
        host_u.select(1'b1);
        host_u.shift(216, 1'b0);
        chk(host_u.rx_bits, frame(1'b0));
        host_u.select(1'b0);
    endtask

    initial begin
        arst_n               = 1'b0;
        conv_valid           = 1'b0;
        single_read_req      = 1'b0;
        continuous_read_mode = 1'b0;
        chain_input_enable   = 1'b0;
        rate_select_field    = 3'h2;
        positive_fault_flags = 8'hA5;
        negative_fault_flags = 8'h3C;
        gpio_data            = 4'h9;
        channel_powered_down = 8'h10;
        channel_results      = {26'h0000080, 26'h3800000, 26'h07FFFFF, 26'h0ABCDEF,
                                26'h3FFFFFF, 26'h2000000, 26'h1000000, 26'h0123456};
        repeat (12) @(posedge clock);
        #1;
        arst_n = 1'b1;
        tick(2);
        t_flag_cs();
        t_din();
        t_wide();
        t_narrow();
        t_overlap();
        wrap_up();
    end
endmodule
